// file: design/pmx_pkg.sv
// constants and carrier types for the pin multiplexer
// Functional notes
// R01 - ports 0/1 address/data when bus on
// R02 - port 2 upper address when control bit 0
// R03 - pins 3.0/3.1 strobes when bus on
// R04 - pin 3.2 low write strobe when bus+enable
// R05 - pin 3.3 high strobe needs bus, 16-bit, enable
// R06 - pins 3.4/3.5 hold request/ack when bus+hold
// R07 - pin 3.6 ready input when bus+ready enabled
// R08 - pin 3.7 bus clock when bus+clock out
// R09 - pins 4.0/4.1 first UART data and clock
// R10 - pins 4.5/4.4 second UART data and clock
// R11 - pins 4.6/4.7 synchronous serial data and clock
// R12 - peripheral inputs always routed
// R13 - port 6 pins analog when enable bit set
// R14 - pull-ups ports 0-3 only while GPIO
// R15 - enabled alternate output overrides port registers
package pmx_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // geometry
    localparam int NUM_PORTS  = 7;   // ports 0 to 6
    localparam int PORT_W     = 8;   // pins per port
    localparam int PULL_PORTS = 4;   // ports 0 to 3 carry pull-ups
    localparam int WB_ADR_W   = 8;   // byte address width of the slave

    // port numbers
    localparam int P_AD_LO  = 0;     // low address/data byte
    localparam int P_AD_HI  = 1;     // high address/data byte
    localparam int P_UPPER  = 2;     // upper address lines
    localparam int P_STROBE = 3;     // bus strobes and handshakes
    localparam int P_SERIAL = 4;     // serial outputs and inputs
    localparam int P_INPUT  = 5;     // interrupt, trigger, timer inputs
    localparam int P_ANALOG = 6;     // analog channels

    // pin positions inside port 3
    localparam int B_ALE  = 0;       // address latch strobe
    localparam int B_RD   = 1;       // read strobe
    localparam int B_WRL  = 2;       // low write strobe
    localparam int B_WRH  = 3;       // high write strobe
    localparam int B_HREQ = 4;       // hold request in
    localparam int B_HACK = 5;       // hold acknowledge out
    localparam int B_RDY  = 6;       // ready in
    localparam int B_CLK  = 7;       // bus clock out

    // pin positions inside port 4
    localparam int B_A_TXD  = 0;
    localparam int B_A_SCLK = 1;
    localparam int B_A_RXD  = 2;
    localparam int B_B_RXD  = 3;
    localparam int B_B_SCLK = 4;
    localparam int B_B_TXD  = 5;
    localparam int B_S_DOUT = 6;
    localparam int B_S_SCLK = 7;

    // pin positions inside port 5
    localparam int B_S_DIN = 0;
    localparam int B_IRQ0  = 1;      // first of four interrupt inputs
    localparam int B_TRIG  = 5;
    localparam int B_TMR   = 6;

    ////////////////////////////////////////////////////////////////////////////
    // register map, byte offsets
    localparam logic [7:0] REG_MODE_CTRL   = 8'h00;  // mode and function enables
    localparam logic [7:0] REG_UPPER_ADDR  = 8'h04;  // upper_addr_out_ctrl
    localparam logic [7:0] REG_ANALOG_EN   = 8'h08;  // analog input enable
    localparam logic [7:0] REG_DATA_BASE   = 8'h20;  // port data, 4 bytes apart
    localparam logic [7:0] REG_DIR_BASE    = 8'h40;  // port direction
    localparam logic [7:0] REG_PULL_BASE   = 8'h60;  // pull-up enables
    localparam logic [7:0] REG_LEVEL_BASE  = 8'h80;  // pin levels, read only
    localparam logic [7:0] REG_BLOCK_MASK  = 8'hE0;  // selects a port block
    localparam logic [7:0] REG_IDX_MASK    = 8'h1C;  // selects a port within it

    // mode control fields
    localparam int CTRL_EXT_BUS = 0;  // external bus enabled
    localparam int CTRL_BUS16   = 1;  // 16-bit bus
    localparam int CTRL_WRL_EN  = 2;  // low write strobe output
    localparam int CTRL_WRH_EN  = 3;  // high write strobe output
    localparam int CTRL_HOLD_EN = 4;  // hold function
    localparam int CTRL_RDY_EN  = 5;  // external ready function
    localparam int CTRL_CLK_EN  = 6;  // bus clock output

    // reset values
    localparam logic [7:0] RST_MODE_CTRL  = 8'h00;
    localparam logic [7:0] RST_UPPER_ADDR = 8'h00;
    localparam logic [7:0] RST_ANALOG_EN  = 8'h00;
    localparam logic [7:0] RST_PORT       = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef logic [NUM_PORTS-1:0][PORT_W-1:0] pmx_pins_t;

    typedef struct packed {
        logic [15:0] ad_out;            // address/data drive value
        logic [15:0] ad_oe;             // address/data drive enable
        logic [7:0]  upper_addr_lines;  // address 16 to 23
        logic        ale;
        logic        rd;
        logic        write_strobe_low;
        logic        write_strobe_high;
        logic        bus_hold_ack;
        logic        bus_clk;
    } pmx_bus_out_t;

    typedef struct packed {
        logic [15:0] ad_in;             // address/data read back
        logic        bus_hold_request;
        logic        ext_ready;
    } pmx_bus_in_t;

    typedef struct packed {
        logic uart_a_txd;
        logic uart_a_txd_en;
        logic uart_a_sclk;
        logic uart_a_sclk_en;
        logic uart_b_txd;
        logic uart_b_txd_en;
        logic uart_b_sclk;
        logic uart_b_sclk_en;
        logic sync_serial_dout;
        logic sync_serial_dout_en;
        logic sync_serial_sclk;
        logic sync_serial_sclk_en;
    } pmx_ser_out_t;

    typedef struct packed {
        logic       uart_a_rxd;
        logic       uart_a_sclk_in;
        logic       uart_b_rxd;
        logic       uart_b_sclk_in;
        logic       sync_serial_din;
        logic       sync_serial_sclk_in;
        logic [3:0] ext_irq_inputs_hi;
        logic       converter_trigger_in;
        logic       timer_event_in;
    } pmx_ser_in_t;

endpackage

// file: design/pmx_port_cell.sv
// registered port cell: alternate or port drive per pin
`timescale 1ns/1ps
module pmx_port_cell
    import pmx_pkg::*;
#(
    parameter int W = PORT_W
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] alt_en_i,      // alternate function owns pin
    input  wire logic [W-1:0] alt_out_i,     // alternate drive value
    input  wire logic [W-1:0] alt_oe_i,      // alternate drive enable
    input  wire logic [W-1:0] port_data_i,   // port data register
    input  wire logic [W-1:0] port_dir_i,    // port direction, 1 = out
    input  wire logic [W-1:0] analog_i,      // pin given to converter
    output logic      [W-1:0] pin_out_o,
    output logic      [W-1:0] pin_oe_o
);

    ////////////////////////////////////////////////////////////////////////////
    // drive value: alternate wins while enabled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_out_o <= '0;
        end else begin
            pin_out_o <= (alt_en_i & alt_out_i) | (~alt_en_i & port_data_i); // R15
        end
    end

    // drive enable: analog off, then alternate, then port
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_oe_o <= '0;
        end else begin
            pin_oe_o <= ~analog_i & ((alt_en_i & alt_oe_i) | (~alt_en_i & port_dir_i)); // R15
        end
    end

endmodule

// file: design/pmx_pin_mux.sv
// shared pin multiplexer with wishbone registers
`timescale 1ns/1ps
module pmx_pin_mux
    import pmx_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // wishbone slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [WB_ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    // peripheral side
    input  wire pmx_bus_out_t        bus_ctl_i,
    input  wire pmx_ser_out_t        ser_ctl_i,
    output pmx_bus_in_t              bus_in_o,
    output pmx_ser_in_t              ser_in_o,
    output logic      [PORT_W-1:0]   analog_channel_pins_o,
    // pins
    input  wire pmx_pins_t           pin_in_i,
    output pmx_pins_t                pin_out_o,
    output pmx_pins_t                pin_oe_o,
    output logic [PULL_PORTS*PORT_W-1:0] pull_up_o
);

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] mode_ctrl_reg;                 // mode and enables
    logic [7:0] upper_addr_out_ctrl_reg;       // 1 keeps pin as port
    logic [7:0] analog_en_reg;                 // 1 gives pin to converter
    logic [NUM_PORTS-1:0][PORT_W-1:0] data_reg; // port data
    logic [NUM_PORTS-1:0][PORT_W-1:0] dir_reg;  // port direction
    logic [PULL_PORTS-1:0][PORT_W-1:0] pull_reg; // pull-up requests
    pmx_pins_t  level_reg;                     // sampled pin levels
    logic       ack_reg;                       // bus answer
    logic [31:0] rdata_reg;                    // bus read data

    // alternate function selection
    pmx_pins_t  alt_en;
    pmx_pins_t  alt_out;
    pmx_pins_t  alt_oe;
    logic [31:0] rd_next;                      // read mux result
    logic       wr_hit;                        // write takes effect now

    // decoded mode bits
    logic ext_bus;
    logic hold_on;
    logic ready_on;

    ////////////////////////////////////////////////////////////////////////////
    // address helpers
    function automatic logic [2:0] port_idx(input logic [WB_ADR_W-1:0] a);
        port_idx = 3'((a & REG_IDX_MASK) >> 2);
    endfunction

    function automatic logic in_block(input logic [WB_ADR_W-1:0] a,
                                      input logic [7:0] base,
                                      input int unsigned count);
        in_block = ((a & REG_BLOCK_MASK) == base)
                   && (32'(port_idx(a)) < count)
                   && (a[1:0] == 2'b00);
    endfunction

    assign ext_bus  = mode_ctrl_reg[CTRL_EXT_BUS];
    assign hold_on  = ext_bus & mode_ctrl_reg[CTRL_HOLD_EN];
    assign ready_on = ext_bus & mode_ctrl_reg[CTRL_RDY_EN];

    ////////////////////////////////////////////////////////////////////////////
    // ack one cycle after each request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
        end
    end

    // write lands on the acked edge
    assign wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg & wb_sel_i[0];

    // read data captured with the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= '0;
        end else if (wb_cyc_i & wb_stb_i & ~ack_reg & ~wb_we_i) begin
            rdata_reg <= rd_next;
        end else if (ack_reg) begin
            rdata_reg <= '0;
        end
    end

    // read mux, unmapped reads as zero
    always_comb begin
        rd_next = '0;
        if (wb_adr_i == REG_MODE_CTRL) begin
            rd_next[7:0] = mode_ctrl_reg;
        end else if (wb_adr_i == REG_UPPER_ADDR) begin
            rd_next[7:0] = upper_addr_out_ctrl_reg;
        end else if (wb_adr_i == REG_ANALOG_EN) begin
            rd_next[7:0] = analog_en_reg;
        end else if (in_block(wb_adr_i, REG_DATA_BASE, NUM_PORTS)) begin
            rd_next[7:0] = data_reg[port_idx(wb_adr_i)];
        end else if (in_block(wb_adr_i, REG_DIR_BASE, NUM_PORTS)) begin
            rd_next[7:0] = dir_reg[port_idx(wb_adr_i)];
        end else if (in_block(wb_adr_i, REG_PULL_BASE, PULL_PORTS)) begin
            rd_next[7:0] = pull_reg[2'(port_idx(wb_adr_i))];
        end else if (in_block(wb_adr_i, REG_LEVEL_BASE, NUM_PORTS)) begin
            rd_next[7:0] = level_reg[port_idx(wb_adr_i)];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode, upper address, analog
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_ctrl_reg           <= RST_MODE_CTRL;
            upper_addr_out_ctrl_reg <= RST_UPPER_ADDR;
            analog_en_reg           <= RST_ANALOG_EN;
        end else if (wr_hit) begin
            if (wb_adr_i == REG_MODE_CTRL) begin
                mode_ctrl_reg <= wb_dat_i[7:0];
            end
            if (wb_adr_i == REG_UPPER_ADDR) begin
                upper_addr_out_ctrl_reg <= wb_dat_i[7:0];
            end
            if (wb_adr_i == REG_ANALOG_EN) begin
                analog_en_reg <= wb_dat_i[7:0];
            end
        end
    end

    // port data, direction, pull-up
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_reg <= '0;
            dir_reg  <= '0;
            pull_reg <= '0;
        end else if (wr_hit) begin
            if (in_block(wb_adr_i, REG_DATA_BASE, NUM_PORTS)) begin
                data_reg[port_idx(wb_adr_i)] <= wb_dat_i[7:0];
            end
            if (in_block(wb_adr_i, REG_DIR_BASE, NUM_PORTS)) begin
                dir_reg[port_idx(wb_adr_i)] <= wb_dat_i[7:0];
            end
            if (in_block(wb_adr_i, REG_PULL_BASE, PULL_PORTS)) begin
                pull_reg[2'(port_idx(wb_adr_i))] <= wb_dat_i[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // alternate output selection per pin
    always_comb begin
        alt_en  = '0;
        alt_out = '0;
        alt_oe  = '0;
        // address/data bus owns ports 0 and 1
        alt_en[P_AD_LO]  = {PORT_W{ext_bus}}; // R01
        alt_en[P_AD_HI]  = {PORT_W{ext_bus}}; // R01
        alt_out[P_AD_LO] = bus_ctl_i.ad_out[7:0];
        alt_out[P_AD_HI] = bus_ctl_i.ad_out[15:8];
        alt_oe[P_AD_LO]  = bus_ctl_i.ad_oe[7:0];
        alt_oe[P_AD_HI]  = bus_ctl_i.ad_oe[15:8];
        // upper address where control bit clear
        alt_en[P_UPPER]  = {PORT_W{ext_bus}} & ~upper_addr_out_ctrl_reg; // R02
        alt_out[P_UPPER] = bus_ctl_i.upper_addr_lines;
        alt_oe[P_UPPER]  = '1;
        // strobes
        alt_en[P_STROBE][B_ALE]  = ext_bus; // R03
        alt_out[P_STROBE][B_ALE] = bus_ctl_i.ale;
        alt_oe[P_STROBE][B_ALE]  = 1'b1;
        alt_en[P_STROBE][B_RD]   = ext_bus; // R03
        alt_out[P_STROBE][B_RD]  = bus_ctl_i.rd;
        alt_oe[P_STROBE][B_RD]   = 1'b1;
        alt_en[P_STROBE][B_WRL]  = ext_bus & mode_ctrl_reg[CTRL_WRL_EN]; // R04
        alt_out[P_STROBE][B_WRL] = bus_ctl_i.write_strobe_low;
        alt_oe[P_STROBE][B_WRL]  = 1'b1;
        alt_en[P_STROBE][B_WRH]  = ext_bus & mode_ctrl_reg[CTRL_BUS16]
                                   & mode_ctrl_reg[CTRL_WRH_EN]; // R05
        alt_out[P_STROBE][B_WRH] = bus_ctl_i.write_strobe_high;
        alt_oe[P_STROBE][B_WRH]  = 1'b1;
        // hold request is an input
        alt_en[P_STROBE][B_HREQ] = hold_on; // R06
        alt_en[P_STROBE][B_HACK] = hold_on; // R06
        alt_out[P_STROBE][B_HACK] = bus_ctl_i.bus_hold_ack;
        alt_oe[P_STROBE][B_HACK]  = 1'b1;
        // ready is an input
        alt_en[P_STROBE][B_RDY]  = ready_on; // R07
        alt_en[P_STROBE][B_CLK]  = ext_bus & mode_ctrl_reg[CTRL_CLK_EN]; // R08
        alt_out[P_STROBE][B_CLK] = bus_ctl_i.bus_clk;
        alt_oe[P_STROBE][B_CLK]  = 1'b1;
        // first uart
        alt_en[P_SERIAL][B_A_TXD]   = ser_ctl_i.uart_a_txd_en; // R09
        alt_out[P_SERIAL][B_A_TXD]  = ser_ctl_i.uart_a_txd;
        alt_en[P_SERIAL][B_A_SCLK]  = ser_ctl_i.uart_a_sclk_en; // R09
        alt_out[P_SERIAL][B_A_SCLK] = ser_ctl_i.uart_a_sclk;
        // second uart
        alt_en[P_SERIAL][B_B_TXD]   = ser_ctl_i.uart_b_txd_en; // R10
        alt_out[P_SERIAL][B_B_TXD]  = ser_ctl_i.uart_b_txd;
        alt_en[P_SERIAL][B_B_SCLK]  = ser_ctl_i.uart_b_sclk_en; // R10
        alt_out[P_SERIAL][B_B_SCLK] = ser_ctl_i.uart_b_sclk;
        // synchronous serial interface
        alt_en[P_SERIAL][B_S_DOUT]  = ser_ctl_i.sync_serial_dout_en; // R11
        alt_out[P_SERIAL][B_S_DOUT] = ser_ctl_i.sync_serial_dout;
        alt_en[P_SERIAL][B_S_SCLK]  = ser_ctl_i.sync_serial_sclk_en; // R11
        alt_out[P_SERIAL][B_S_SCLK] = ser_ctl_i.sync_serial_sclk;
        // every serial output drives while enabled
        alt_oe[P_SERIAL] = alt_en[P_SERIAL];
    end

    ////////////////////////////////////////////////////////////////////////////
    // one registered cell per port
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        pmx_port_cell #(
            .W (PORT_W)
        ) u_cell (
            .clk_i       (clk_i),
            .rst_i       (rst_i),
            .alt_en_i    (alt_en[p]),
            .alt_out_i   (alt_out[p]),
            .alt_oe_i    (alt_oe[p]),
            .port_data_i (data_reg[p]),
            .port_dir_i  (dir_reg[p]),
            .analog_i    ((p == P_ANALOG) ? analog_en_reg : '0),
            .pin_out_o   (pin_out_o[p]),
            .pin_oe_o    (pin_oe_o[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // sampled pin levels, analog bits read 0
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_reg <= '0;
        end else begin
            level_reg <= pin_in_i;
            level_reg[P_ANALOG] <= pin_in_i[P_ANALOG] & ~analog_en_reg;  // R13
        end
    end

    // converter channel selection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            analog_channel_pins_o <= '0;
        end else begin
            analog_channel_pins_o <= analog_en_reg; // R13
        end
    end

    // pull-ups only on port pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pull_up_o <= '0;
        end else begin
            for (int p = 0; p < PULL_PORTS; p++) begin
                pull_up_o[p*PORT_W +: PORT_W] <= pull_reg[p] & ~alt_en[p]; // R14
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // inputs to the bus controller
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_in_o <= '0;
            bus_in_o.ext_ready <= 1'b1;
        end else begin
            bus_in_o.ad_in <= {pin_in_i[P_AD_HI], pin_in_i[P_AD_LO]};
            bus_in_o.bus_hold_request <= hold_on & pin_in_i[P_STROBE][B_HREQ]; // R06
            bus_in_o.ext_ready <= ~ready_on | pin_in_i[P_STROBE][B_RDY]; // R07
        end
    end

    // peripheral inputs are always routed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ser_in_o <= '0;
        end else begin
            ser_in_o.uart_a_rxd           <= pin_in_i[P_SERIAL][B_A_RXD]; // R12
            ser_in_o.uart_a_sclk_in       <= pin_in_i[P_SERIAL][B_A_SCLK];
            ser_in_o.uart_b_rxd           <= pin_in_i[P_SERIAL][B_B_RXD]; // R12
            ser_in_o.uart_b_sclk_in       <= pin_in_i[P_SERIAL][B_B_SCLK];
            ser_in_o.sync_serial_din      <= pin_in_i[P_INPUT][B_S_DIN]; // R12
            ser_in_o.sync_serial_sclk_in  <= pin_in_i[P_SERIAL][B_S_SCLK];
            ser_in_o.ext_irq_inputs_hi    <= pin_in_i[P_INPUT][B_IRQ0 +: 4];  // R12
            ser_in_o.converter_trigger_in <= pin_in_i[P_INPUT][B_TRIG]; // R12
            ser_in_o.timer_event_in       <= pin_in_i[P_INPUT][B_TMR]; // R12
        end
    end

    // bus outputs
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

endmodule

// file: verification/pmx_pin_mux_sva.sv
// assertion checker for the shared pin multiplexer
`timescale 1ns/1ps
module pmx_pin_mux_sva
    import pmx_pkg::*;
(
    input wire logic                clk_i,
    input wire logic                rst_i,
    input wire logic                wb_cyc_i,
    input wire logic                wb_stb_i,
    input wire logic                wb_we_i,
    input wire logic [WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0]          wb_sel_i,
    input wire logic [31:0]         wb_dat_i,
    input wire logic                wb_ack_o,
    input wire pmx_bus_out_t        bus_ctl_i,
    input wire pmx_ser_out_t        ser_ctl_i,
    input wire pmx_bus_in_t         bus_in_o,
    input wire pmx_ser_in_t         ser_in_o,
    input wire pmx_pins_t           pin_in_i,
    input wire pmx_pins_t           pin_out_o,
    input wire pmx_pins_t           pin_oe_o,
    input wire logic [31:0]         pull_up_o
);
    logic [7:0] mode_reg;  // shadow of mode control
    logic [1:0] rst_q;     // masks two edges after reset
    wire        wr_mode = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0]
                          & (wb_adr_i == REG_MODE_CTRL);
    wire        bus_on  = mode_reg[0];
    wire        hold_on = mode_reg[0] & mode_reg[4];
    wire        rdy_on  = mode_reg[0] & mode_reg[5];
    // shadow follows the acked write
    always_ff @(posedge clk_i) begin
        rst_q <= {rst_q[0], rst_i};
        if (rst_i) begin
            mode_reg <= 8'h00;
        end else if (wr_mode) begin
            mode_reg <= wb_dat_i[7:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || (|rst_q));
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
    AST_ACK_PULSE: assert property (s_req |=> s_ack)
        else $error("ack not one cycle");
    AST_AD_BUS: assert property ($past(bus_on) |->
        {pin_out_o[1], pin_out_o[0]} == $past(bus_ctl_i.ad_out)
        && {pin_oe_o[1], pin_oe_o[0]} == $past(bus_ctl_i.ad_oe)) else $error("ad pins");
    AST_STROBES: assert property ($past(bus_on) |-> pin_oe_o[3][1:0] == 2'h3
        && pin_out_o[3][1:0] == {$past(bus_ctl_i.rd), $past(bus_ctl_i.ale)})
        else $error("strobe pins");
    AST_HOLD: assert property ($past(hold_on) |-> !pin_oe_o[3][4]
        && pin_out_o[3][5] == $past(bus_ctl_i.bus_hold_ack)
        && bus_in_o.bus_hold_request == $past(pin_in_i[3][4])) else $error("hold pins");
    AST_READY: assert property (bus_in_o.ext_ready ==
        ($past(rdy_on) ? $past(pin_in_i[3][6]) : 1'h1)) else $error("ready input");
    AST_SER_IN: assert property (ser_in_o.uart_a_rxd == $past(pin_in_i[4][2])
        && ser_in_o.ext_irq_inputs_hi == $past(pin_in_i[5][4:1])
        && ser_in_o.timer_event_in == $past(pin_in_i[5][6])) else $error("inputs");
    AST_TXD: assert property ($past(ser_ctl_i.uart_a_txd_en) |-> pin_oe_o[4][0]
        && pin_out_o[4][0] == $past(ser_ctl_i.uart_a_txd)) else $error("txd pin");
    AST_PULL: assert property ($past(bus_on) |-> pull_up_o[15:0] == 16'h0000
        && pull_up_o[25:24] == 2'h0) else $error("pull-up on bus pin");
endmodule
bind pmx_pin_mux pmx_pin_mux_sva pmx_pin_mux_sva_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .bus_ctl_i(bus_ctl_i),
    .ser_ctl_i(ser_ctl_i), .bus_in_o(bus_in_o), .ser_in_o(ser_in_o), .pin_in_i(pin_in_i),
    .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pull_up_o(pull_up_o));

// file: verification/pmx_ext_model.sv
// far-side memories and peripherals on the shared pins
`timescale 1ns/1ps
module pmx_ext_model
    import pmx_pkg::*;
(
    input  wire pmx_pins_t pin_out_i,  // multiplexer drive values
    input  wire pmx_pins_t pin_oe_i,   // multiplexer drive enables
    input  wire pmx_pins_t ext_i,      // far-side drive, changed per test
    output pmx_pins_t      pin_in_o    // resolved pin levels
);
    // released pins carry the far side's value, never the last driven one
    assign pin_in_o = (pin_out_i & pin_oe_i) | (ext_i & ~pin_oe_i);
endmodule

// file: verification/pmx_pin_mux_tb.sv
// self-checking bench for the shared pin multiplexer
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module pmx_pin_mux_tb
    import pmx_pkg::*;
;
    logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, ack;
    logic [7:0]   adr = 8'h00, cfg, u, pd[NUM_PORTS], an_o;
    logic [31:0]  wdat = 32'h0, rdat, pull_o, mon_exp, exp_q[$];
    logic [63:0]  rnd;
    logic [15:0]  ad;
    pmx_bus_out_t bc = '0;   // bus controller drive
    pmx_ser_out_t sc = '0;   // serial peripheral drive
    pmx_bus_in_t  bi_o;
    pmx_ser_in_t  si_o;
    pmx_pins_t    pin_in, pin_out, pin_oe, ext = '0;
    int           num_errors = 0, samples_checked = 0, seed = 51443;
    always #5 clk_i = ~clk_i;
    pmx_pin_mux pmx_pin_mux_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .bus_ctl_i(bc), .ser_ctl_i(sc), .bus_in_o(bi_o), .ser_in_o(si_o),
        .analog_channel_pins_o(an_o), .pin_in_i(pin_in), .pin_out_o(pin_out),
        .pin_oe_o(pin_oe), .pull_up_o(pull_o));
    pmx_ext_model pmx_ext_model_i (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .ext_i(ext),
        .pin_in_o(pin_in));
    // one classic cycle, released at ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] dv);
        @(posedge clk_i);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, dv};
        do @(posedge clk_i); while (ack !== 1'h1);
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        wb(1'h0, a, 8'h00);
    endtask
    // settle, then read a port level
    task automatic lvl(input int p, input logic [7:0] e);
        repeat (3) @(posedge clk_i);
        rd(REG_LEVEL_BASE + 8'(4 * p), e);
    endtask
    function automatic logic [7:0] mix(logic [7:0] v, logic [7:0] m, logic [7:0] d);
        return (v & m) | (d & ~m);
    endfunction
    task automatic complete_run();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // read answers against the oldest note
    always @(posedge clk_i) begin
        if (ack === 1'h1 && we === 1'h0) begin
            mon_exp = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hXXXX_XXXX;
            `CHK(rdat, mon_exp)
        end
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        complete_run();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'h0;
        rd(REG_MODE_CTRL, RST_MODE_CTRL);
        rd(REG_UPPER_ADDR, RST_UPPER_ADDR);
        wb(1'h1, 8'hFC, 8'hFF);
        rd(8'hFC, 8'h00);
        // single-chip: every pin follows its port registers
        for (int p = 0; p < NUM_PORTS; p++) begin
            pd[p] = 8'($random(seed));
            wb(1'h1, REG_DIR_BASE + 8'(4 * p), 8'hFF);
            wb(1'h1, REG_DATA_BASE + 8'(4 * p), pd[p]);
            if (p < PULL_PORTS) wb(1'h1, REG_PULL_BASE + 8'(4 * p), 8'hFF);
            lvl(p, pd[p]);
        end
        // corner modes, then random
        for (int i = 0; i < 16; i++) begin
            cfg = (i == 0) ? 8'h7F : (i == 1) ? 8'h7D : (i == 2) ? 8'h7E : 8'($random(seed));
            u = 8'($random(seed));
            rnd = {$random(seed), $random(seed)};
            bc <= rnd[$bits(pmx_bus_out_t)-1:0];
            sc <= rnd[63:52];
            rnd = {$random(seed), $random(seed)};
            ext <= rnd[55:0];
            wb(1'h1, REG_MODE_CTRL, cfg & 8'h7F);
            wb(1'h1, REG_UPPER_ADDR, u);
            ad = (bc.ad_out & bc.ad_oe) | ({ext[1], ext[0]} & ~bc.ad_oe);
            lvl(0, cfg[0] ? ad[7:0] : pd[0]);
            lvl(1, cfg[0] ? ad[15:8] : pd[1]);
            lvl(2, mix(bc.upper_addr_lines, ~u & {8{cfg[0]}}, pd[2]));
            lvl(3, mix({bc.bus_clk, ext[3][6], bc.bus_hold_ack, ext[3][4],
                bc.write_strobe_high, bc.write_strobe_low, bc.rd, bc.ale}, {cfg[6], cfg[5],
                cfg[4], cfg[4], cfg[1] & cfg[3], cfg[2], 2'h3} & {8{cfg[0]}}, pd[3]));
            lvl(4, mix({sc.sync_serial_sclk, sc.sync_serial_dout, sc.uart_b_txd,
                sc.uart_b_sclk, 2'h0, sc.uart_a_sclk, sc.uart_a_txd}, {sc.sync_serial_sclk_en,
                sc.sync_serial_dout_en, sc.uart_b_txd_en, sc.uart_b_sclk_en, 2'h0,
                sc.uart_a_sclk_en, sc.uart_a_txd_en}, pd[4]));
        end
        // analog channels and input-only port 5
        u = 8'($random(seed));
        wb(1'h1, REG_ANALOG_EN, u);
        lvl(6, pd[6] & ~u);
        `CHK(an_o, u)
        wb(1'h1, REG_DIR_BASE + 8'h14, 8'h00);
        lvl(5, ext[5]);
        repeat (4) @(posedge clk_i);
        `CHK(exp_q.size(), 0)
        complete_run();
    end
endmodule
